// File: framer_device.sv
// Codec end: reorder buffer control, statistics, stream builder and parser
`timescale 1ns/1ns
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] cnt;
  } fifo_state_type;
  fifo_state_type q, n;
  logic push, pop;

  always_comb begin
    n = q;
    push = in_valid_i && (q.cnt != DEPTH[AW:0]);
    pop = out_ready_i && (q.cnt != '0);
    if (push) begin
      n.mem[q.wr] = in_data_i;
      n.wr = q.wr + 1'b1;
    end
    if (pop) begin
      n.rd = q.rd + 1'b1;
    end
    n.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= n;
    end
  end

  assign in_ready_o = (q.cnt != DEPTH[AW:0]);
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o = q.mem[q.rd];
endmodule : word_fifo

// Overview of operation
// - Reorder coefficients into bitstream block order
// - Gather field statistics before emitting blocks
// - Device issues all memory and refresh cycles
// - One 256K x 16 60 ns memory attached
// - Stream out when encoding, in when decoding
// - Alternating fields, host ends with sequence end
// - Field start, timecode, first block, remaining blocks
// - First block: type code, width, data, block 6
// - Exactly 41 further blocks follow first block
// - Block: start variant, 16-bit width, data
// - Block 9 variant four, then variant-three run
// - Alternating run with variants one and three
// - Final twelve blocks, variants four and two
// - Each field coded as independent sequence
// - Bin widths supplied by outside party
// - Delimiters start on 32-bit word boundaries
// - Field start delimiter resets parsing alone
// - Timecode is 12 bytes carried per field
module framer_device import wavelet_framer_pkg::*; (
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // Link
  stream_link_if.device lnk,
  // Coefficients from the transform
  input wire logic coef_valid_i,
  input wire logic [POS_W-1:0] coef_block_i,
  input wire logic [COEF_W-1:0] coef_data_i,
  input wire logic coef_field_end_i,
  input wire logic coef_field_two_i,
  input wire logic [TIMECODE_WORDS*WORD_W-1:0] timecode_i,
  input wire logic [BLOCKS-1:0][COEF_W-1:0] bin_width_i,
  output logic coef_ready_o,
  // Field statistics
  output logic stat_valid_o,
  output logic [COEF_W-1:0] stat_min_o,
  output logic [COEF_W-1:0] stat_max_o,
  output logic [31:0] stat_sum_o,
  output logic [47:0] stat_sumsq_o,
  // Reorder memory
  output logic [MEM_AW-1:0] mem_addr_o,
  output logic [COEF_W-1:0] mem_wdata_o,
  output logic mem_we_o,
  output logic mem_re_o,
  output logic mem_refresh_o,
  input wire logic [COEF_W-1:0] mem_rdata_i,
  // Decoded stream
  output logic dec_valid_o,
  output logic [POS_W-1:0] dec_block_o,
  output logic [COEF_W-1:0] dec_bin_width_o,
  output logic [COEF_W-1:0] dec_data_o,
  output logic [TIMECODE_WORDS*WORD_W-1:0] dec_timecode_o,
  output logic field_two_o,
  output logic seq_done_o,
  output logic fmt_err_o
);
  typedef struct packed {
    dev_state_type st;
    logic [POS_W-1:0] pos;
    logic [BLOCK_AW-1:0] idx;
    logic [2:0] wt;
    logic [10:0] rf;
    logic [BLOCKS-1:0][CNT_W-1:0] cnt;
    logic fld2;
    logic [COEF_W-1:0] rd;
    logic [COEF_W-1:0] mn;
    logic [COEF_W-1:0] mx;
    logic [31:0] sum;
    logic [47:0] sq;
    logic coef_rdy;
    logic h2d_rdy;
    logic [MEM_AW-1:0] addr;
    logic [COEF_W-1:0] wd;
    logic we;
    logic re;
    logic refr;
    logic sv;
    logic [COEF_W-1:0] smn;
    logic [COEF_W-1:0] smx;
    logic [31:0] ssum;
    logic [47:0] ssq;
    logic dv;
    logic [POS_W-1:0] dblk;
    logic [COEF_W-1:0] dbw;
    logic [COEF_W-1:0] dd;
    logic [TIMECODE_WORDS-1:0][WORD_W-1:0] dtc;
    logic dfld2;
    logic done;
    logic err;
  } dev_state_reg_type;
  dev_state_reg_type q, n;

  logic push_valid, push_ready, accept, take, mem_busy;
  logic [WORD_W-1:0] push_data, w;
  logic [POS_W-1:0] blk;
  logic [31:0] sqr;

  word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_out_fifo (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .in_valid_i(push_valid),
    .in_data_i(push_data),
    .in_ready_o(push_ready),
    .out_valid_o(lnk.d2h_valid),
    .out_data_o(lnk.d2h_data),
    .out_ready_i(lnk.d2h_ready)
  );

  always_comb begin
    n = q;
    n.we = 1'b0;
    n.re = 1'b0;
    n.refr = 1'b0;
    n.sv = 1'b0;
    n.dv = 1'b0;
    n.done = 1'b0;
    n.err = 1'b0;
    push_valid = 1'b0;
    push_data = '0;
    w = lnk.h2d_data;
    take = lnk.h2d_valid && q.h2d_rdy;
    accept = coef_valid_i && q.coef_rdy;
    blk = block_at(q.pos);
    sqr = 32'(coef_data_i * coef_data_i);
    // ****************************************
    // Memory refresh, slotted between accesses
    // ****************************************
    mem_busy = accept || (q.st == ST_E_WAIT);
    if (q.rf == '0 && !mem_busy) begin
      n.refr = 1'b1;
      n.rf = 11'(REFRESH_CYCLES - 1);
    end else if (q.rf != '0) begin
      n.rf = q.rf - 1'b1;
    end
    case (q.st)
      ST_IDLE: begin
        n.pos = '0;
        n.idx = '0;
        n.st = lnk.encode ? ST_COLLECT : ST_D_HUNT;
        n.mn = '1;
        n.mx = '0;
        n.sum = '0;
        n.sq = '0;
      end
      // ****************************************
      // Encode: buffer one field and gather statistics
      // ****************************************
      ST_COLLECT: begin
        if (!lnk.encode) n.st = ST_IDLE;
        if (accept) begin
          n.addr = {coef_block_i, q.cnt[coef_block_i][BLOCK_AW-1:0]};
          n.wd = coef_data_i;
          n.we = 1'b1;
          n.cnt[coef_block_i] = q.cnt[coef_block_i] + 1'b1;
          if (coef_data_i < q.mn) n.mn = coef_data_i;
          if (coef_data_i > q.mx) n.mx = coef_data_i;
          n.sum = q.sum + {16'h0, coef_data_i};
          n.sq = q.sq + {16'h0, sqr};
        end
        if (coef_field_end_i && q.coef_rdy) begin
          n.sv = 1'b1;
          n.smn = n.mn;
          n.smx = n.mx;
          n.ssum = n.sum;
          n.ssq = n.sq;
          n.fld2 = coef_field_two_i;
          n.st = ST_E_DHI;
        end
      end
      ST_E_DHI: begin
        push_valid = 1'b1;
        push_data = DELIM_MARK;
        if (push_ready) n.st = ST_E_DLO;
      end
      ST_E_DLO: begin
        push_valid = 1'b1;
        if (q.pos == '0) begin
          push_data = q.fld2 ? FIELD_TWO_CODE : FIELD_ONE_CODE;
        end else if (q.cnt[blk] == '0) begin
          push_data = block_code(VARIANT_FIVE);
        end else begin
          push_data = block_code(BLOCK_VARIANT[q.pos]);
        end
        if (push_ready) n.st = (q.pos == '0) ? ST_E_TC : ST_E_BW;
      end
      ST_E_TC: begin
        push_valid = 1'b1;
        push_data = timecode_i[q.idx[1:0]*WORD_W +: WORD_W];
        if (push_ready) begin
          n.idx = q.idx + 1'b1;
          if (q.idx == BLOCK_AW'(TIMECODE_WORDS - 1)) begin
            n.idx = '0;
            n.st = ST_E_TYPE;
          end
        end
      end
      ST_E_TYPE: begin
        push_valid = 1'b1;
        push_data = {24'h0, FIRST_BLOCK_TYPE_CODE};
        if (push_ready) n.st = ST_E_BW;
      end
      ST_E_BW: begin
        push_valid = 1'b1;
        push_data = {16'h0, bin_width_i[blk]};
        n.idx = '0;
        if (push_ready) n.st = (q.cnt[blk] == '0) ? ST_E_PUSH : ST_E_RD;
      end
      ST_E_RD: begin
        if (q.rf != '0) begin
          n.addr = {blk, q.idx};
          n.re = 1'b1;
          n.wt = 3'(MEM_ACCESS_CYCLES - 1);
          n.st = ST_E_WAIT;
        end
      end
      ST_E_WAIT: begin
        if (q.wt == '0) begin
          n.rd = mem_rdata_i;
          n.st = ST_E_PUSH;
        end else begin
          n.wt = q.wt - 1'b1;
        end
      end
      ST_E_PUSH: begin
        push_valid = (q.cnt[blk] != '0);
        push_data = {16'h0, q.rd};
        if (push_ready || !push_valid) begin
          n.idx = q.idx + 1'b1;
          if (push_valid && {1'b0, q.idx} + 1'b1 != q.cnt[blk]) begin
            n.st = ST_E_RD;
          end else if (q.pos == LAST_POS) begin
            n.cnt = '0;
            n.st = ST_IDLE;
          end else begin
            n.pos = q.pos + 1'b1;
            n.st = ST_E_DHI;
          end
        end
      end
      // ****************************************
      // Decode: parse the incoming stream
      // ****************************************
      ST_D_HUNT: begin
        if (lnk.encode) n.st = ST_IDLE;
        else if (take && w == DELIM_MARK) n.st = ST_D_CODE;
      end
      ST_D_CODE: begin
        if (take) begin
          n.idx = '0;
          if (w == FIELD_ONE_CODE || w == FIELD_TWO_CODE) begin
            n.pos = '0;
            n.dfld2 = (w == FIELD_TWO_CODE);
            n.st = ST_D_TC;
          end else if (w == SEQ_END_CODE) begin
            n.done = 1'b1;
            n.st = ST_IDLE;
          end else if ((w & BLOCK_CODE_MASK) == BLOCK_CODE_BASE && q.pos != LAST_POS) begin
            n.pos = q.pos + 1'b1;
            n.err = (w[2:0] != VARIANT_FIVE) && (w[2:0] != BLOCK_VARIANT[n.pos]);
            n.st = ST_D_BW;
          end else begin
            n.err = 1'b1;
            n.st = ST_D_HUNT;
          end
        end
      end
      ST_D_TC: begin
        if (take) begin
          n.dtc[q.idx[1:0]] = w;
          n.idx = q.idx + 1'b1;
          if (q.idx == BLOCK_AW'(TIMECODE_WORDS - 1)) n.st = ST_D_TYPE;
        end
      end
      ST_D_TYPE: begin
        if (take) begin
          n.err = (w[7:0] != FIRST_BLOCK_TYPE_CODE);
          n.st = ST_D_BW;
        end
      end
      ST_D_BW: begin
        if (take) begin
          n.dblk = blk;
          n.dbw = w[COEF_W-1:0];
          n.st = ST_D_DATA;
          if (w == DELIM_MARK) n.st = ST_D_CODE;
        end
      end
      ST_D_DATA: begin
        if (take) begin
          if (w == DELIM_MARK) begin
            n.st = ST_D_CODE;
          end else begin
            n.dv = 1'b1;
            n.dd = w[COEF_W-1:0];
          end
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
    // Ready is registered, so it looks one state ahead
    n.coef_rdy = (n.st == ST_COLLECT) && !(n.rf == '0) && !(coef_field_end_i && q.coef_rdy);
    n.h2d_rdy = n.st[3] && (n.st != ST_E_WAIT) && (n.st != ST_E_PUSH) && (q.st != ST_IDLE);
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= n;
    end
  end

  assign lnk.h2d_ready = q.h2d_rdy;
  assign coef_ready_o = q.coef_rdy;
  assign stat_valid_o = q.sv;
  assign stat_min_o = q.smn;
  assign stat_max_o = q.smx;
  assign stat_sum_o = q.ssum;
  assign stat_sumsq_o = q.ssq;
  assign mem_addr_o = q.addr;
  assign mem_wdata_o = q.wd;
  assign mem_we_o = q.we;
  assign mem_re_o = q.re;
  assign mem_refresh_o = q.refr;
  assign dec_valid_o = q.dv;
  assign dec_block_o = q.dblk;
  assign dec_bin_width_o = q.dbw;
  assign dec_data_o = q.dd;
  assign dec_timecode_o = q.dtc;
  assign field_two_o = q.dfld2;
  assign seq_done_o = q.done;
  assign fmt_err_o = q.err;
endmodule : framer_device

// File: wavelet_framer_pkg.sv
// Shared constants, block order tables and state types for the field bitstream framer
package wavelet_framer_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int WORD_W = 32;
  localparam int COEF_W = 16;
  localparam int BLOCKS = 42;
  localparam int POS_W = 6;
  localparam int BLOCK_AW = 12;
  localparam int CNT_W = BLOCK_AW + 1;
  localparam int MEM_AW = POS_W + BLOCK_AW;
  localparam int TIMECODE_WORDS = 3;
  localparam int FIFO_DEPTH = 16;
  localparam logic [POS_W-1:0] LAST_POS = 6'h29;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS = 10;
  localparam int MEM_ACCESS_NS = 60;
  localparam int MEM_ACCESS_CYCLES = (MEM_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int REFRESH_NS = 15600;
  localparam int REFRESH_CYCLES = REFRESH_NS / CLK_NS;
  // ****************************************
  // Stream codes
  // ****************************************
  localparam logic [WORD_W-1:0] DELIM_MARK = 32'hffffffff;
  localparam logic [WORD_W-1:0] FIELD_ONE_CODE = 32'h40000000;
  localparam logic [WORD_W-1:0] FIELD_TWO_CODE = 32'h41000000;
  localparam logic [WORD_W-1:0] SEQ_END_CODE = 32'h4f000000;
  localparam logic [WORD_W-1:0] BLOCK_CODE_BASE = 32'h50000000;
  localparam logic [WORD_W-1:0] BLOCK_CODE_MASK = 32'hfffffff8;
  localparam logic [7:0] FIRST_BLOCK_TYPE_CODE = 8'h03;
  localparam logic [2:0] VARIANT_FIVE = 3'h5;
  // Bitstream position to block number, position 0 first
  localparam logic [0:BLOCKS-1][POS_W-1:0] BLOCK_ORDER = {
    6'h06, 6'h09, 6'h14, 6'h16, 6'h13, 6'h17, 6'h11, 6'h19, 6'h10, 6'h1a, 6'h0e, 6'h1c, 6'h0d, 6'h1d,
    6'h0b, 6'h1f, 6'h0a, 6'h20, 6'h08, 6'h22, 6'h07, 6'h23, 6'h05, 6'h25, 6'h04, 6'h26, 6'h02, 6'h28,
    6'h01, 6'h29, 6'h00, 6'h27, 6'h0c, 6'h24, 6'h0f, 6'h21, 6'h12, 6'h1e, 6'h15, 6'h1b, 6'h18, 6'h03};
  // Delimiter variant per position; position 0 has none
  localparam logic [0:BLOCKS-1][2:0] BLOCK_VARIANT = {
    3'h0, 3'h4, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3,
    3'h1, 3'h1, 3'h3, 3'h1, 3'h3, 3'h1, 3'h3, 3'h1, 3'h3, 3'h1, 3'h3, 3'h1, 3'h3, 3'h1,
    3'h3, 3'h1, 3'h4, 3'h2, 3'h4, 3'h2, 3'h4, 3'h2, 3'h4, 3'h2, 3'h2, 3'h2, 3'h2, 3'h4};

  function automatic logic [POS_W-1:0] block_at(input logic [POS_W-1:0] pos);
    block_at = BLOCK_ORDER[pos];
  endfunction : block_at

  function automatic logic [WORD_W-1:0] block_code(input logic [2:0] v);
    block_code = BLOCK_CODE_BASE | {29'h0, v};
  endfunction : block_code

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000, ST_COLLECT = 4'b0001, ST_E_DHI = 4'b0010, ST_E_DLO = 4'b0011,
    ST_E_TC = 4'b0100, ST_E_TYPE = 4'b0101, ST_E_BW = 4'b0110, ST_E_RD = 4'b0111,
    ST_E_WAIT = 4'b1000, ST_E_PUSH = 4'b1001, ST_D_HUNT = 4'b1010, ST_D_CODE = 4'b1011,
    ST_D_TC = 4'b1100, ST_D_TYPE = 4'b1101, ST_D_BW = 4'b1110, ST_D_DATA = 4'b1111
  } dev_state_type;
endpackage : wavelet_framer_pkg

// File: stream_link_if.sv
// Word stream link between the codec end and the host end
`timescale 1ns/1ns
interface stream_link_if;
  logic encode;
  logic d2h_valid;
  logic [31:0] d2h_data;
  logic d2h_ready;
  logic h2d_valid;
  logic [31:0] h2d_data;
  logic h2d_ready;
  modport device (input encode, input d2h_ready, input h2d_valid, input h2d_data,
                  output d2h_valid, output d2h_data, output h2d_ready);
  modport host (output encode, output d2h_ready, output h2d_valid, output h2d_data,
                input d2h_valid, input d2h_data, input h2d_ready);
endinterface : stream_link_if

// File: framer_host.sv
// Host end: drains the encoded stream and feeds the stream to be decoded
`timescale 1ns/1ns
module framer_host import wavelet_framer_pkg::*; (
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // Link
  stream_link_if.host lnk,
  // Mode
  input wire logic encode_i,
  // Encoded words to the user
  output logic rx_valid_o,
  output logic [WORD_W-1:0] rx_data_o,
  input wire logic rx_ready_i,
  // Words to decode from the user
  input wire logic tx_valid_i,
  input wire logic [WORD_W-1:0] tx_data_i,
  input wire logic tx_end_i,
  output logic tx_ready_o
);
  typedef struct packed {
    logic enc;
    logic rxv;
    logic [WORD_W-1:0] rxd;
    logic d2h_rdy;
    logic h2dv;
    logic [WORD_W-1:0] h2dd;
    logic [1:0] eos;
    logic tx_rdy;
  } host_state_type;
  host_state_type q, n;

  always_comb begin
    n = q;
    n.enc = encode_i;
    if (rx_ready_i) n.rxv = 1'b0;
    if (lnk.d2h_valid && q.d2h_rdy) begin
      n.rxv = 1'b1;
      n.rxd = lnk.d2h_data;
    end
    if (lnk.h2d_ready) n.h2dv = 1'b0;
    // Half rate on purpose: a slot is only refilled once empty
    if (!n.h2dv) begin
      if (q.eos == 2'h2) begin
        n.h2dv = 1'b1;
        n.h2dd = DELIM_MARK;
        n.eos = 2'h1;
      end else if (q.eos == 2'h1) begin
        n.h2dv = 1'b1;
        n.h2dd = SEQ_END_CODE;
        n.eos = 2'h0;
      end else if (q.tx_rdy && tx_end_i) begin
        n.eos = 2'h2;
      end else if (q.tx_rdy && tx_valid_i) begin
        n.h2dv = 1'b1;
        n.h2dd = tx_data_i;
      end
    end
    n.d2h_rdy = !n.rxv;
    n.tx_rdy = !n.h2dv && (n.eos == 2'h0) && !(q.tx_rdy && (tx_valid_i || tx_end_i));
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= n;
    end
  end

  assign lnk.encode = q.enc;
  assign lnk.d2h_ready = q.d2h_rdy;
  assign lnk.h2d_valid = q.h2dv;
  assign lnk.h2d_data = q.h2dd;
  assign rx_valid_o = q.rxv;
  assign rx_data_o = q.rxd;
  assign tx_ready_o = q.tx_rdy;
endmodule : framer_host

// File: framer_link_chk.sv
// Concurrent checks on the word link
`timescale 1ns/1ns
module framer_link_chk import wavelet_framer_pkg::*; (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Link signals
  input wire logic encode,
  input wire logic d2h_valid,
  input wire logic [31:0] d2h_data,
  input wire logic d2h_ready,
  input wire logic h2d_valid,
  input wire logic [31:0] h2d_data,
  input wire logic h2d_ready
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);
  // ****************************************
  // Stream position tracking
  // ****************************************
  logic xfer, is_field, is_block, mark_q, fld_q;
  logic [2:0] wi_q;
  logic [5:0] pos_q;
  assign xfer = d2h_valid && d2h_ready;
  assign is_field = mark_q && (d2h_data == FIELD_ONE_CODE || d2h_data == FIELD_TWO_CODE);
  assign is_block = mark_q && ((d2h_data & BLOCK_CODE_MASK) == BLOCK_CODE_BASE);
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      mark_q <= 1'h0;
      fld_q <= 1'h0;
      wi_q <= 3'h0;
      pos_q <= 6'h00;
    end else if (xfer) begin
      mark_q <= (d2h_data == DELIM_MARK);
      if (is_field) begin
        fld_q <= 1'h1;
        wi_q <= 3'h1;
        pos_q <= 6'h00;
      end else begin
        // Saturates; payload never wraps to header slots
        if (wi_q != 3'h0 && wi_q != 3'h7) wi_q <= wi_q + 3'h1;
        if (is_block) pos_q <= pos_q + 6'h01;
      end
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  a_d2h_word_hold: assert property (d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data))
    else $error("d2h word not held");
  a_h2d_word_hold: assert property (h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
    else $error("h2d word not held");
  a_enc_out_mode: assert property ($rose(d2h_valid) |-> encode)
    else $error("d2h valid in decode");
  a_dec_in_mode: assert property (h2d_ready |-> !encode)
    else $error("h2d ready in encode");
  a_mark_then_code: assert property (xfer && mark_q |-> is_field || is_block)
    else $error("bad code after mark");
  a_type_after_tc: assert property (xfer && wi_q == 3'h4 |-> d2h_data == {24'h000000, FIRST_BLOCK_TYPE_CODE})
    else $error("bad first type word");
  a_first_bw_width: assert property (xfer && wi_q == 3'h5 |-> d2h_data[31:16] == 16'h0000)
    else $error("wide first bin width");
  a_variant_order: assert property (xfer && is_block |-> pos_q < 6'h29 &&
    (d2h_data[2:0] == BLOCK_VARIANT[pos_q + 6'h01] || d2h_data[2:0] == VARIANT_FIVE))
    else $error("bad block variant");
  a_block_count: assert property (xfer && is_field && fld_q |-> pos_q == 6'h29)
    else $error("block count wrong");
endmodule : framer_link_chk

// File: wavelet_field_bitstream_framer_tb.sv
// Self-checking bench, both framer ends joined
`timescale 1ns/1ns
module wavelet_field_bitstream_framer_tb import wavelet_framer_pkg::*;;
  // ****************************************
  // Signals and instances
  // ****************************************
  localparam int ORD[42] = '{6, 9, 20, 22, 19, 23, 17, 25, 16, 26, 14, 28, 13, 29, 11, 31, 10, 32, 8, 34, 7,
    35, 5, 37, 4, 38, 2, 40, 1, 41, 0, 39, 12, 36, 15, 33, 18, 30, 21, 27, 24, 3};
  localparam int VAR[42] = '{0, 4, 3, 3, 3, 3, 3, 3, 3, 3, 3, 3, 3, 3, 1, 1, 3, 1, 3, 1, 3,
    1, 3, 1, 3, 1, 3, 1, 3, 1, 4, 2, 4, 2, 4, 2, 4, 2, 2, 2, 2, 4};
  localparam int CB[5] = '{3, 41, 0, 9, 6};
  logic clk_sys_i = 1'h0;
  logic srst_i = 1'h1;
  logic encode_i = 1'h1;
  logic coef_valid_i = 1'h0;
  logic [POS_W-1:0] coef_block_i = 6'h00;
  logic [COEF_W-1:0] coef_data_i = 16'h0000;
  logic coef_field_end_i = 1'h0;
  logic coef_field_two_i = 1'h0;
  logic [95:0] timecode_i = 96'h0123456789abcdef02468ace;
  logic [BLOCKS-1:0][COEF_W-1:0] bin_width_i;
  logic [COEF_W-1:0] mem_rdata_i = 16'h0000;
  logic rx_ready_i = 1'h0;
  logic tx_valid_i = 1'h0;
  logic [31:0] tx_data_i = 32'h00000000;
  logic tx_end_i = 1'h0;
  logic coef_ready_o, stat_valid_o, mem_we_o, mem_re_o, mem_refresh_o, dec_valid_o;
  logic field_two_o, seq_done_o, fmt_err_o, rx_valid_o, tx_ready_o;
  logic [COEF_W-1:0] stat_min_o, stat_max_o, dec_bin_width_o, dec_data_o, mem_wdata_o;
  logic [31:0] stat_sum_o, rx_data_o;
  logic [47:0] stat_sumsq_o;
  logic [MEM_AW-1:0] mem_addr_o;
  logic [POS_W-1:0] dec_block_o;
  logic [95:0] dec_timecode_o;
  logic [COEF_W-1:0] mem [0:(1<<MEM_AW)-1];
  logic [31:0] sq[$];
  logic [37:0] eq[$], dq[$];
  int mismatches = 0;
  int comparisons = 0;
  int dones = 0, errs = 0, refreshes = 0;
  stream_link_if lnk();
  framer_device framer_device_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(1'h1), .lnk(lnk.device),
    .coef_valid_i(coef_valid_i), .coef_block_i(coef_block_i), .coef_data_i(coef_data_i),
    .coef_field_end_i(coef_field_end_i), .coef_field_two_i(coef_field_two_i), .timecode_i(timecode_i),
    .bin_width_i(bin_width_i), .coef_ready_o(coef_ready_o), .stat_valid_o(stat_valid_o),
    .stat_min_o(stat_min_o), .stat_max_o(stat_max_o), .stat_sum_o(stat_sum_o), .stat_sumsq_o(stat_sumsq_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o), .mem_re_o(mem_re_o),
    .mem_refresh_o(mem_refresh_o), .mem_rdata_i(mem_rdata_i), .dec_valid_o(dec_valid_o),
    .dec_block_o(dec_block_o), .dec_bin_width_o(dec_bin_width_o), .dec_data_o(dec_data_o),
    .dec_timecode_o(dec_timecode_o), .field_two_o(field_two_o), .seq_done_o(seq_done_o), .fmt_err_o(fmt_err_o));
  framer_host framer_host_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(1'h1), .lnk(lnk.host),
    .encode_i(encode_i), .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o), .rx_ready_i(rx_ready_i),
    .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i), .tx_end_i(tx_end_i), .tx_ready_o(tx_ready_o));
  framer_link_chk chk_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .encode(lnk.encode),
    .d2h_valid(lnk.d2h_valid), .d2h_data(lnk.d2h_data), .d2h_ready(lnk.d2h_ready),
    .h2d_valid(lnk.h2d_valid), .h2d_data(lnk.h2d_data), .h2d_ready(lnk.h2d_ready));
  always #5 clk_sys_i = ~clk_sys_i;
  // Read data holds until the next read
  always @(posedge clk_sys_i) begin
    if (mem_we_o) mem[mem_addr_o] <= mem_wdata_o;
    if (mem_re_o) mem_rdata_i <= mem[mem_addr_o];
    if (dec_valid_o) dq.push_back({dec_block_o, dec_bin_width_o, dec_data_o});
    if (seq_done_o) dones++;
    if (fmt_err_o) errs++;
    if (mem_refresh_o) refreshes++;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic stop_test();
    if (mismatches == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic guard(inout int n);
    n++;
    if (n > 5000) begin
      mismatches++;
      stop_test();
    end
  endtask : guard
  function automatic logic [15:0] cval(input int b, input int i);
    cval = 16'(b * 256 + i + 1);
  endfunction : cval
  // Expected words and payload of one field
  task automatic build(input logic two);
    int b;
    int n;
    sq = {DELIM_MARK, two ? FIELD_TWO_CODE : FIELD_ONE_CODE, timecode_i[31:0], timecode_i[63:32], timecode_i[95:64]};
    sq.push_back(32'h00000003);
    eq = {};
    for (int p = 0; p < 42; p++) begin
      b = ORD[p];
      n = (b inside {3, 41, 0, 9, 6}) ? 2 : 0;
      if (p > 0) begin
        sq.push_back(DELIM_MARK);
        sq.push_back(32'h50000000 + 32'(n > 0 ? VAR[p] : 5));
      end
      sq.push_back({16'h0000, bin_width_i[b]});
      for (int i = 0; i < n; i++) begin
        sq.push_back({16'h0000, cval(b, i)});
        eq.push_back({6'(b), bin_width_i[b], cval(b, i)});
      end
    end
  endtask : build
  // Flag by number: 0 coef ready, 1 stats valid, 2 rx valid, 3 tx ready
  task automatic wait_hi(input int s);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      guard(n);
    end while ((s == 0 ? coef_ready_o : s == 1 ? stat_valid_o : s == 2 ? rx_valid_o : tx_ready_o) !== 1'h1);
  endtask : wait_hi
  task automatic send(input logic [31:0] w, input logic fin);
    tx_valid_i <= !fin;
    tx_end_i <= fin;
    tx_data_i <= w;
    wait_hi(3);
  endtask : send
  task automatic send_all();
    foreach (sq[k]) send(sq[k], 1'h0);
    tx_valid_i <= 1'h0;
  endtask : send_all
  task automatic cmp_dec(input logic two);
    repeat (20) @(posedge clk_sys_i);
    check(32'(dq.size()), 32'(eq.size()));
    foreach (eq[k]) check(dq[k], eq[k]);
    check(field_two_o, two);
    check(dec_timecode_o, timecode_i);
    dq = {};
  endtask : cmp_dec
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic refresh_gap();
    int r0;
    @(negedge clk_sys_i);
    r0 = refreshes;
    repeat (3120) @(negedge clk_sys_i);
    check(32'(refreshes - r0), 32'h2);
  endtask : refresh_gap
  // Host stalls until the buffer refuses
  task automatic enc_field(input logic two);
    logic [15:0] v, mn, mx;
    logic [31:0] sm;
    logic [47:0] ss;
    mn = 16'hffff;
    mx = 16'h0000;
    sm = 32'h0;
    ss = 48'h0;
    build(two);
    foreach (CB[j]) for (int i = 0; i < 2; i++) begin
      v = cval(CB[j], i);
      mn = (v < mn) ? v : mn;
      mx = (v > mx) ? v : mx;
      sm += 32'(v);
      ss += 48'(v) * 48'(v);
      coef_valid_i <= 1'h1;
      coef_block_i <= 6'(CB[j]);
      coef_data_i <= v;
      wait_hi(0);
    end
    coef_valid_i <= 1'h0;
    coef_field_end_i <= 1'h1;
    coef_field_two_i <= two;
    wait_hi(0);
    coef_field_end_i <= 1'h0;
    wait_hi(1);
    check(lnk.d2h_valid, 1'h0);
    check({stat_min_o, stat_max_o, stat_sum_o, stat_sumsq_o}, {mn, mx, sm, ss});
    repeat (300) @(posedge clk_sys_i);
    check({lnk.d2h_valid, lnk.d2h_ready, coef_ready_o}, 3'h4);
    rx_ready_i <= 1'h1;
    foreach (sq[k]) begin
      wait_hi(2);
      check(rx_data_o, sq[k]);
    end
    repeat (50) @(posedge clk_sys_i);
    check(rx_valid_o, 1'h0);
    rx_ready_i <= 1'h0;
  endtask : enc_field
  // Good field, cut field, field two, end
  task automatic dec_run();
    int n;
    encode_i <= 1'h0;
    repeat (4) @(posedge clk_sys_i);
    build(1'h0);
    send_all();
    cmp_dec(1'h0);
    sq = {DELIM_MARK, FIELD_ONE_CODE, 32'h0, 32'h0, 32'h0, 32'h3, 32'h5, 32'h7, DELIM_MARK, 32'h50000001};
    send_all();
    repeat (20) @(posedge clk_sys_i);
    dq = {};
    build(1'h1);
    send_all();
    cmp_dec(1'h1);
    send(32'h0, 1'h1);
    tx_end_i <= 1'h0;
    n = 0;
    while (dones == 0) begin
      @(posedge clk_sys_i);
      guard(n);
    end
    check(32'(dones), 32'h1);
    check(32'(errs), 32'h1);
  endtask : dec_run
  initial begin
    for (int b = 0; b < BLOCKS; b++) bin_width_i[b] = 16'h1000 + 16'(b);
    bin_width_i[6] = 16'h1ddc;
    repeat (12) @(posedge clk_sys_i);
    srst_i <= 1'h0;
    repeat (2) @(posedge clk_sys_i);
    refresh_gap();
    enc_field(1'h0);
    enc_field(1'h1);
    dec_run();
    stop_test();
  end
endmodule : wavelet_field_bitstream_framer_tb
